// >>> hw/iodr_pkg.sv
// Purpose: constants and types for the inertial output data register bank
// Assumes: 50 MHz reference clock, 16-bit serial words, msb first, serial mode 3
// Notes: offsets are byte addresses of the low byte of each 16-bit word
package iodr_pkg;

    localparam int unsigned CLK_HZ = 50_000_000;
    localparam real SAMPLE_RATE_SPS = 819.2;
    localparam int unsigned SAMPLE_CYCLES = int'($floor(real'(CLK_HZ) / SAMPLE_RATE_SPS));

    localparam int unsigned WORD_W = 16;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned RAW_W = 18;
    localparam int unsigned TEMP_W = 12;
    localparam int unsigned NUM_WORDS = 8;
    localparam int unsigned IDX_W = 3;
    localparam int unsigned BIT_CNT_W = 4;

    // byte offsets of the low byte of each word
    localparam logic [6:0] ADDR_RATE_X = 7'h04;
    localparam logic [6:0] ADDR_RATE_Y = 7'h06;
    localparam logic [6:0] ADDR_RATE_Z = 7'h08;
    localparam logic [6:0] ADDR_ACCEL_X = 7'h0a;
    localparam logic [6:0] ADDR_ACCEL_Y = 7'h0c;
    localparam logic [6:0] ADDR_ACCEL_Z = 7'h0e;
    localparam logic [6:0] ADDR_TEMP = 7'h18;
    localparam logic [6:0] ADDR_DIAG = 7'h3c;

    // serial command word layout
    localparam int unsigned CMD_WRITE_BIT = 15;
    localparam int unsigned CMD_ADDR_MSB = 14;
    localparam int unsigned CMD_ADDR_LSB = 8;
    localparam logic [15:0] CMD_BURST = 16'h3e00;

    // storage index, also the burst order
    localparam logic [2:0] IDX_DIAG = 3'h0;
    localparam logic [2:0] IDX_RATE_X = 3'h1;
    localparam logic [2:0] IDX_RATE_Y = 3'h2;
    localparam logic [2:0] IDX_RATE_Z = 3'h3;
    localparam logic [2:0] IDX_ACCEL_X = 3'h4;
    localparam logic [2:0] IDX_ACCEL_Y = 3'h5;
    localparam logic [2:0] IDX_ACCEL_Z = 3'h6;
    localparam logic [2:0] IDX_TEMP = 3'h7;
    localparam logic [2:0] IDX_BURST_LAST = 3'h7;

    // upper byte of range_filter_ctrl selects the rate scale
    localparam logic [7:0] RANGE_QUARTER = 8'h01;
    localparam logic [7:0] RANGE_HALF = 8'h02;
    localparam logic [7:0] RANGE_FULL = 8'h04;
    localparam logic [1:0] SHIFT_QUARTER = 2'h0;
    localparam logic [1:0] SHIFT_HALF = 2'h1;
    localparam logic [1:0] SHIFT_FULL = 2'h2;

    localparam logic [15:0] WORD_MAX = 16'h7fff;
    localparam logic [15:0] WORD_MIN = 16'h8000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // one sample set from the front end; rates at 400 counts per deg/s
    typedef struct packed {
        logic [15:0] diag;
        logic [17:0] rate_x;
        logic [17:0] rate_y;
        logic [17:0] rate_z;
        logic [15:0] accel_x;
        logic [15:0] accel_y;
        logic [15:0] accel_z;
        logic [11:0] temp;
    } iodr_meas_t;

endpackage : iodr_pkg

// >>> hw/iodr_output_regs.sv
// Purpose: output data register bank read over the serial slave port
// Assumes: front end holds i_meas valid; serial clock at most 2 MHz
// Notes: serial pins are synchronised into the reference clock domain
`timescale 1ns/1ps
`default_nettype none

module iodr_output_regs #(
    parameter int unsigned SAMPLE_CYCLES = iodr_pkg::SAMPLE_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire iodr_pkg::iodr_meas_t i_meas,
    input wire logic [15:0] i_range_filter_ctrl,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sclk,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_sample_done
);

    ////////////////////////////////////////////////////////////////////////////////
    // sample tick

    logic [31:0] tick_cnt_r;
    logic tick;

    assign tick = (tick_cnt_r == SAMPLE_CYCLES - 1);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || tick) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // scaling and storage

    logic [1:0] rate_shift;
    logic [15:0] word_nxt [iodr_pkg::NUM_WORDS];
    logic [15:0] word_r [iodr_pkg::NUM_WORDS];
    logic signed [17:0] raw_rate [3];

    assign rate_shift = (i_range_filter_ctrl[15:8] == iodr_pkg::RANGE_QUARTER) ?
        iodr_pkg::SHIFT_QUARTER :
        (i_range_filter_ctrl[15:8] == iodr_pkg::RANGE_HALF) ? iodr_pkg::SHIFT_HALF :
        iodr_pkg::SHIFT_FULL;

    assign raw_rate[0] = i_meas.rate_x;
    assign raw_rate[1] = i_meas.rate_y;
    assign raw_rate[2] = i_meas.rate_z;

    // saturate rather than wrap on the quarter and half scales
    function automatic logic [15:0] sat16(input logic signed [17:0] v);
        if (v > $signed({2'b00, iodr_pkg::WORD_MAX})) begin
            return iodr_pkg::WORD_MAX;
        end else if (v < $signed({2'b11, iodr_pkg::WORD_MIN})) begin
            return iodr_pkg::WORD_MIN;
        end
        return v[15:0];
    endfunction : sat16

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_rate
            assign word_nxt[int'(iodr_pkg::IDX_RATE_X) + g] =
                sat16(raw_rate[g] >>> rate_shift);
        end
    endgenerate

    assign word_nxt[iodr_pkg::IDX_DIAG] = i_meas.diag;
    assign word_nxt[iodr_pkg::IDX_ACCEL_X] = i_meas.accel_x;
    assign word_nxt[iodr_pkg::IDX_ACCEL_Y] = i_meas.accel_y;
    assign word_nxt[iodr_pkg::IDX_ACCEL_Z] = i_meas.accel_z;
    assign word_nxt[iodr_pkg::IDX_TEMP] = {4'h0, i_meas.temp};

    // all words load on the same edge, so a set never splits
    always_ff @(posedge i_ref_clk) begin
        for (int i = 0; i < int'(iodr_pkg::NUM_WORDS); i++) begin
            if (i_rst) begin
                word_r[i] <= iodr_pkg::WORD_ZERO;
            end else if (tick) begin
                word_r[i] <= word_nxt[i];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_sample_done <= 1'b0;
        end else begin
            o_sample_done <= tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial pin synchronisers

    logic [1:0] cs_sync_r;
    logic [2:0] sclk_sync_r;
    logic [1:0] mosi_sync_r;
    logic cs_n;
    logic sclk_rise;
    logic sclk_fall;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cs_sync_r <= 2'h3;
            sclk_sync_r <= 3'h7;
            mosi_sync_r <= 2'h0;
        end else begin
            cs_sync_r <= {cs_sync_r[0], i_spi_cs_n};
            sclk_sync_r <= {sclk_sync_r[1:0], i_spi_sclk};
            mosi_sync_r <= {mosi_sync_r[0], i_spi_mosi};
        end
    end

    // edge detect looks only at stages two and three
    assign cs_n = cs_sync_r[1];
    assign sclk_rise = !cs_n && sclk_sync_r[1] && !sclk_sync_r[2];
    assign sclk_fall = !cs_n && !sclk_sync_r[1] && sclk_sync_r[2];

    ////////////////////////////////////////////////////////////////////////////////
    // frame shift and command decode

    logic [3:0] bit_cnt_r;
    logic [15:0] rx_r;
    logic [15:0] tx_r;
    logic [15:0] rx_word;
    logic frame_end;
    logic burst_r;
    logic [2:0] burst_idx_r;
    logic [6:0] rd_addr;
    logic is_write;
    logic is_burst;
    logic addr_hit;
    logic [2:0] addr_idx;
    logic [2:0] next_idx;
    logic next_hit;
    logic [15:0] resp_word;

    assign frame_end = sclk_rise && (bit_cnt_r == 4'hf);
    assign rx_word = {rx_r[14:0], mosi_sync_r[1]};
    assign is_write = rx_word[iodr_pkg::CMD_WRITE_BIT];
    assign is_burst = (rx_word == iodr_pkg::CMD_BURST);
    // low address bit dropped: both bytes of a word read the same word
    assign rd_addr = {rx_word[iodr_pkg::CMD_ADDR_MSB:iodr_pkg::CMD_ADDR_LSB + 1], 1'b0};

    assign addr_hit = (rd_addr == iodr_pkg::ADDR_RATE_X) || (rd_addr == iodr_pkg::ADDR_RATE_Y) ||
        (rd_addr == iodr_pkg::ADDR_RATE_Z) || (rd_addr == iodr_pkg::ADDR_ACCEL_X) ||
        (rd_addr == iodr_pkg::ADDR_ACCEL_Y) || (rd_addr == iodr_pkg::ADDR_ACCEL_Z) ||
        (rd_addr == iodr_pkg::ADDR_TEMP) || (rd_addr == iodr_pkg::ADDR_DIAG);
    assign addr_idx = (rd_addr == iodr_pkg::ADDR_RATE_X) ? iodr_pkg::IDX_RATE_X :
        (rd_addr == iodr_pkg::ADDR_RATE_Y) ? iodr_pkg::IDX_RATE_Y :
        (rd_addr == iodr_pkg::ADDR_RATE_Z) ? iodr_pkg::IDX_RATE_Z :
        (rd_addr == iodr_pkg::ADDR_ACCEL_X) ? iodr_pkg::IDX_ACCEL_X :
        (rd_addr == iodr_pkg::ADDR_ACCEL_Y) ? iodr_pkg::IDX_ACCEL_Y :
        (rd_addr == iodr_pkg::ADDR_ACCEL_Z) ? iodr_pkg::IDX_ACCEL_Z :
        (rd_addr == iodr_pkg::ADDR_TEMP) ? iodr_pkg::IDX_TEMP : iodr_pkg::IDX_DIAG;

    // burst carries on regardless of mosi until eight words are out
    assign next_hit = burst_r || is_burst || (!is_write && addr_hit);
    assign next_idx = burst_r ? burst_idx_r + 3'h1 :
        is_burst ? iodr_pkg::IDX_DIAG : addr_idx;
    // word copied whole into the shifter; a later tick cannot tear it
    assign resp_word = next_hit ? word_r[next_idx] : iodr_pkg::WORD_ZERO;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || cs_n) begin
            bit_cnt_r <= 4'h0;
        end else if (sclk_rise) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rx_r <= iodr_pkg::WORD_ZERO;
        end else if (sclk_rise) begin
            rx_r <= rx_word;
        end
    end

    // deselect ends a burst early
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || cs_n) begin
            burst_r <= 1'b0;
            burst_idx_r <= iodr_pkg::IDX_DIAG;
        end else if (frame_end) begin
            burst_r <= (burst_r && (burst_idx_r + 3'h1 != iodr_pkg::IDX_BURST_LAST)) ||
                (!burst_r && is_burst);
            burst_idx_r <= next_idx;
        end
    end

    // mode 3: drive on falling edge, host samples on rising
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            tx_r <= iodr_pkg::WORD_ZERO;
            o_spi_miso <= 1'b0;
        end else if (frame_end) begin
            tx_r <= resp_word;
        end else if (sclk_fall) begin
            o_spi_miso <= tx_r[15];
            tx_r <= {tx_r[14:0], 1'b0};
        end
    end

endmodule : iodr_output_regs

`default_nettype wire

// >>> test/iodr_output_regs_properties.sv
// Purpose: port checks of the output data register bank
// Assumes: one clock domain; serial clock far slower than the reference clock
// Notes: the gap counter restarts at each sample pulse
`timescale 1ns/1ps
`default_nettype none
module iodr_output_regs_properties #(
    parameter int unsigned SAMPLE_CYCLES = 50
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire iodr_pkg::iodr_meas_t i_meas,
    input wire logic [15:0] i_range_filter_ctrl,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sclk,
    input wire logic i_spi_mosi,
    input wire logic o_spi_miso,
    input wire logic o_sample_done
);
    logic [31:0] gap_r;
    logic seen_r;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            gap_r <= 32'h0;
            seen_r <= 1'b0;
        end else begin
            gap_r <= o_sample_done ? 32'h1 : gap_r + 32'h1;
            seen_r <= seen_r | o_sample_done;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    a_done_one_cycle: assert property (o_sample_done |=> !o_sample_done [*8])
        else $error("sample pulse too long");
    a_done_period: assert property (o_sample_done && seen_r |-> gap_r == SAMPLE_CYCLES)
        else $error("sample period wrong");
    a_first_tick: assert property (o_sample_done && !seen_r |-> gap_r == SAMPLE_CYCLES)
        else $error("first sample late or early");
    a_tick_not_late: assert property (gap_r <= SAMPLE_CYCLES)
        else $error("sample pulse missing");
    a_release_quiet: assert property ($fell(i_rst) |-> !o_sample_done && !o_spi_miso)
        else $error("outputs not cleared by reset");
    a_release_no_tick: assert property ($fell(i_rst) |-> !o_sample_done [*8])
        else $error("sample pulse right after reset");
    a_miso_sclk_low: assert property ($changed(o_spi_miso) |-> !i_spi_sclk)
        else $error("serial out moved while clock high");
    a_miso_idle_still: assert property (i_spi_cs_n && $past(i_spi_cs_n, 4) |-> $stable(o_spi_miso))
        else $error("serial out moved while deselected");
endmodule : iodr_output_regs_properties
bind iodr_output_regs iodr_output_regs_properties #(.SAMPLE_CYCLES(SAMPLE_CYCLES))
    iodr_output_regs_properties_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_meas(i_meas),
    .i_range_filter_ctrl(i_range_filter_ctrl), .i_spi_cs_n(i_spi_cs_n), .i_spi_sclk(i_spi_sclk),
    .i_spi_mosi(i_spi_mosi), .o_spi_miso(o_spi_miso), .o_sample_done(o_sample_done));
`default_nettype wire

// >>> test/iodr_spi_master.sv
// Purpose: serial master standing in for the host processor
// Assumes: mode 3, 16-bit words, msb first
// Notes: 25-cycle half bit gives a 1 MHz serial clock, fit for bursts too
`timescale 1ns/1ps
`default_nettype none
module iodr_spi_master (
    input wire logic i_ref_clk,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_mosi,
    input wire logic i_miso
);
    localparam int HALF = 25;
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b1;
        o_mosi = 1'b0;
    end
    ////////////////////////////////////////
    // full duplex: command goes out while the previous reply comes in
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx, input logic hold = 1'b0);
        @(negedge i_ref_clk);
        o_cs_n = 1'b0;
        repeat (HALF) @(negedge i_ref_clk);
        for (int i = 15; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_mosi = tx[i];
            repeat (HALF) @(negedge i_ref_clk);
            o_sclk = 1'b1;
            rx[i] = i_miso;
            repeat (HALF) @(negedge i_ref_clk);
        end
        // select stays low between burst words, else the burst ends
        o_cs_n = !hold;
        o_mosi = ~o_mosi;
        repeat (HALF) @(negedge i_ref_clk);
    endtask : xfer
endmodule : iodr_spi_master
`default_nettype wire

// >>> test/iodr_output_regs_test.sv
// Purpose: self-checking bench of the output data register bank
// Assumes: sample period shortened to 50 cycles
// Notes: each reply belongs to the command of the frame before
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", what, exp, got); end end
module iodr_output_regs_test;
    localparam logic [15:0] BURST_EXP [8] = '{16'h0024, 16'h61a8, 16'h9e58, 16'h01f4,
        16'h4e20, 16'hb1e0, 16'hffff, 16'h0c3e};
    localparam logic [15:0] Z_EXP [3] = '{16'h07d0, 16'h03e8, 16'h01f4};
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    iodr_pkg::iodr_meas_t meas = '{16'h0024, 18'h186a0, 18'h27960, 18'h007d0, 16'h4e20,
        16'hb1e0, 16'hffff, 12'hc3e};
    logic [15:0] range_ctrl = 16'h0402;
    logic cs_n, sclk, mosi, miso, sample_done;
    logic [15:0] rx, last_cmd;
    int miscompares = 0;
    int cmp_count = 0;
    initial begin
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    iodr_output_regs #(.SAMPLE_CYCLES(50)) iodr_output_regs_inst (.i_ref_clk(i_ref_clk),
        .i_rst(i_rst), .i_meas(meas), .i_range_filter_ctrl(range_ctrl), .i_spi_cs_n(cs_n),
        .i_spi_sclk(sclk), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_sample_done(sample_done));
    iodr_spi_master iodr_spi_master_inst (.i_ref_clk(i_ref_clk), .o_cs_n(cs_n), .o_sclk(sclk),
        .o_mosi(mosi), .i_miso(miso));
    ////////////////////////////////////////
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic step(input logic [15:0] cmd, input logic [15:0] exp, input logic hold = 1'b0);
        iodr_spi_master_inst.xfer(cmd, rx, hold);
        `CHECK($sformatf("reply to %h", last_cmd), exp, rx)
        last_cmd = cmd;
    endtask : step
    task automatic wait_done;
        int n;
        for (n = 0; n < 200 && sample_done !== 1'b1; n++) begin
            @(negedge i_ref_clk);
        end
        if (n == 200) begin
            miscompares++;
            $display("MISMATCH sample pulse expected 1 seen %b", sample_done);
            report_and_stop();
        end
        @(negedge i_ref_clk);
    endtask : wait_done
    ////////////////////////////////////////
    initial begin
        repeat (16) @(negedge i_ref_clk);
        i_rst = 1'b0;
        wait_done();
        iodr_spi_master_inst.xfer(16'h0400, rx);
        last_cmd = 16'h0400;
        step(16'h0600, 16'h61a8);
        step(16'h0800, 16'h9e58);
        step(16'h0a00, 16'h01f4);
        step(16'h0c00, 16'h4e20);
        step(16'h0e00, 16'hb1e0);
        step(16'h1800, 16'hffff);
        step(16'h0500, 16'h0c3e);
        step(16'h8412, 16'h61a8);
        step(16'h0400, 16'h0000);
        step(16'h0400, 16'h61a8);
        // front end moves mid-frame; the reply must still be the old word whole
        fork
            step(16'h1000, 16'h61a8);
            begin
                repeat (400) @(negedge i_ref_clk);
                meas.rate_x = 18'h00004;
            end
        join
        meas.rate_x = 18'h186a0;
        step(16'h3e00, 16'h0000, 1'b1);
        $display("test single reads done");
        for (int i = 0; i < 8; i++) begin
            step(16'h0000, BURST_EXP[i], i < 7);
        end
        $display("test burst done");
        meas.temp = 12'h3ea;
        for (int k = 0; k < 3; k++) begin
            range_ctrl = {8'h01 << k, 8'h02};
            wait_done();
            wait_done();
            iodr_spi_master_inst.xfer(16'h1800, rx);
            last_cmd = 16'h1800;
            step(16'h0800, 16'h03ea);
            step(16'h0000, Z_EXP[k]);
        end
        $display("test range and temperature done");
        report_and_stop();
    end
endmodule : iodr_output_regs_test
`default_nettype wire
